// File: tb/tb_wdt_top.sv
`timescale 1ns/1ps
module tb_wdt_top;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        wdt_irq;
  logic        cpu_reset_req;
  logic [31:0] rdata;
  int          n_mismatch = 0;
  int          total_checks = 0;

  wdt_top i_wdt_top (
    .ref_clk         (ref_clk),
    .rst_n           (rst_n),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .wdt_irq         (wdt_irq),
    .cpu_reset_req   (cpu_reset_req)
  );

  // 40 MHz clock
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One access; the extra edge lets flags from the write settle
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 50)
    begin
      n_mismatch++;
      print_verdict();
    end
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Bounded wait for an interrupt or a reset request
  task automatic wait_ev(input int lim);
    int n;
    n = 0;
    while (wdt_irq !== 1'b1 && cpu_reset_req !== 1'b1 && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == lim)
    begin
      n_mismatch++;
      print_verdict();
    end
    @(posedge ref_clk);
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  // Reset values, last address unmapped
  task automatic t_reset_values;
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, 8'(i * 4), 32'h0);
      check(rdata, 32'h0, "reset read");
    end
    $display("done reset values");
  endtask

  // Byte lanes: partial writes merge into load and config
  task automatic t_lanes;
    avs_byteenable <= 4'h1;
    bus(1'b1, 8'h00, 32'h0000_1234);
    avs_byteenable <= 4'h2;
    bus(1'b1, 8'h00, 32'h0000_ab00);
    bus(1'b1, 8'h08, 32'h0000_01ff);
    avs_byteenable <= 4'hf;
    bus(1'b0, 8'h00, 32'h0);
    check(rdata, 32'hab34, "lane load");
    bus(1'b0, 8'h04, 32'h0);
    check(rdata, 32'hab34, "lane count");
    bus(1'b0, 8'h08, 32'h0);
    check(rdata, 32'h100, "lane config");
    bus(1'b1, 8'h08, 32'h0);
    $display("done lanes");
  endtask

  // Free-running wrap, then /16 holds the count past one tick
  task automatic t_free;
    do_reset();
    bus(1'b1, 8'h00, 32'h0001);
    bus(1'b1, 8'h08, 32'h0080);
    wait_ev(4000);
    check({31'h0, wdt_irq}, 32'h1, "free irq");
    repeat (1300) @(posedge ref_clk);
    bus(1'b0, 8'h04, 32'h0);
    check(rdata, 32'hffff, "free wrap");
    bus(1'b1, 8'h08, 32'h0084);
    bus(1'b1, 8'h00, 32'h0003);
    repeat (1300) @(posedge ref_clk);
    bus(1'b0, 8'h04, 32'h0);
    check(rdata, 32'h3, "div16 hold");
    $display("done free");
  endtask

  // Periodic count; code 11 must tick at /1 or the wait runs out
  task automatic t_normal;
    bus(1'b1, 8'h00, 32'hffff0002);
    bus(1'b0, 8'h00, 32'h0);
    check(rdata, 32'h2, "load");
    bus(1'b1, 8'h08, 32'h00cc);
    wait_ev(4000);
    check({31'h0, wdt_irq}, 32'h1, "irq at zero");
    check({31'h0, cpu_reset_req}, 32'h0, "normal reset");
    bus(1'b1, 8'h0c, 32'h005a);
    check({31'h0, wdt_irq}, 32'h0, "irq cleared");
    wait_ev(4000);
    check({31'h0, wdt_irq}, 32'h1, "periodic irq");
    $display("done normal");
  endtask

  // Expiry gives a reset, or an irq with the option bit
  task automatic t_expiry(input logic opt);
    do_reset();
    bus(1'b1, 8'h00, 32'h0002);
    bus(1'b1, 8'h08, {26'h0, 1'b1, 3'h0, opt, 1'b0});
    wait_ev(4000);
    check({31'h0, wdt_irq}, {31'h0, opt}, "expiry irq");
    check({31'h0, cpu_reset_req}, {31'h0, !opt}, "expiry reset");
    if (opt)
    begin
      bus(1'b1, 8'h0c, 32'h0011);
      bus(1'b0, 8'h04, 32'h0);
      check(rdata, 32'h2, "reloaded count");
    end
    $display("done expiry");
  endtask

  // Seeded secure service, locked registers, then a wrong value
  task automatic t_secure;
    logic [7:0] s;
    s = 8'haa;
    do_reset();
    bus(1'b1, 8'h0c, {24'h0, s});
    bus(1'b1, 8'h00, 32'h0008);
    bus(1'b1, 8'h08, 32'h0030);
    bus(1'b1, 8'h08, 32'h0000);
    bus(1'b1, 8'h00, 32'h0005);
    bus(1'b0, 8'h08, 32'h0);
    check(rdata, 32'h30, "locked config");
    bus(1'b0, 8'h00, 32'h0);
    check(rdata, 32'h8, "locked load");
    bus(1'b0, 8'h10, 32'h0);
    check(rdata, 32'h2, "status watchdog");
    repeat (3)
    begin
      bus(1'b1, 8'h0c, {24'h0, s});
      check({31'h0, cpu_reset_req}, 32'h0, "good service");
      s = {s[6:0], 1'b0} ^ (s[7] ? 8'h63 : 8'h00);
    end
    bus(1'b1, 8'h0c, 32'h0066);
    check({31'h0, cpu_reset_req}, 32'h1, "bad service");
    bus(1'b0, 8'h10, 32'h0);
    check(rdata, 32'h4, "status tripped");
    do_reset();
    bus(1'b1, 8'h0c, 32'h0000);
    bus(1'b1, 8'h08, 32'h0030);
    bus(1'b1, 8'h0c, 32'h0000);
    check({31'h0, cpu_reset_req}, 32'h1, "zero seed");
    $display("done secure");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard, well past the longest waits
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    print_verdict();
  end

  initial
  begin
    do_reset();
    t_reset_values();
    t_lanes();
    t_normal();
    t_free();
    t_expiry(1'b0);
    t_expiry(1'b1);
    t_secure();
    print_verdict();
  end
endmodule

// File: tb/wdt_top_monitor.sv
`timescale 1ns/1ps
module wdt_top_monitor (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        wdt_irq,
  input wire logic        cpu_reset_req
);
  // Write to the clear register completing at this edge
  wire logic clr_done = avs_write && !avs_waitrequest && avs_address == 8'h0c && avs_byteenable[0];
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Request seen while waiting, and a read of one address being taken
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_rd(logic [7:0] a);
    avs_read && avs_waitrequest && avs_address == a;
  endsequence
  property p_one_wait;
    s_taken |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("answer not one wait");
  property p_rd_clear;
    s_rd(8'h0c) |=> avs_readdata == 32'h0;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("clear reg readable");
  property p_rd_load;
    s_rd(8'h00) |=> avs_readdata[31:16] == 16'h0;
  endproperty
  a_rd_load: assert property (p_rd_load) else $error("load wider than 16");
  property p_rd_cfg;
    s_rd(8'h08) |=> avs_readdata[31:9] == 23'h0 && !avs_readdata[0];
  endproperty
  a_rd_cfg: assert property (p_rd_cfg) else $error("config spare bits set");
  property p_irq_hold;
    wdt_irq && !clr_done |=> wdt_irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped alone");
  // A failed secure service may keep the irq, but then it trips
  property p_irq_clear;
    clr_done && !cpu_reset_req |=> !wdt_irq || cpu_reset_req;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
  property p_reset_hold;
    cpu_reset_req |=> cpu_reset_req;
  endproperty
  a_reset_hold: assert property (p_reset_hold) else $error("reset request dropped");
  property p_quiet;
    $rose(rst_n) |-> !wdt_irq && !cpu_reset_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("event out of reset");
endmodule

bind wdt_top wdt_top_monitor i_wdt_top_monitor (
  .ref_clk         (ref_clk),
  .rst_n           (rst_n),
  .avs_address     (avs_address),
  .avs_read        (avs_read),
  .avs_write       (avs_write),
  .avs_byteenable  (avs_byteenable),
  .avs_readdata    (avs_readdata),
  .avs_waitrequest (avs_waitrequest),
  .wdt_irq         (wdt_irq),
  .cpu_reset_req   (cpu_reset_req)
);

// File: verilog/wdt_pkg.sv
package wdt_pkg;

  // Clocking: the 32 kHz tick is made from ref_clk by a rounded divider
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned SLOW_HZ       = 32_768;
  localparam int unsigned SLOW_DIV      = (CLK_HZ + SLOW_HZ / 2) / SLOW_HZ;
  localparam logic [10:0] SLOW_DIV_LAST = 11'(SLOW_DIV - 1);

  // Register byte offsets
  localparam logic [7:0] OFS_LOAD   = 8'h00;
  localparam logic [7:0] OFS_COUNT  = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_CLEAR  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // Configuration field positions
  localparam int unsigned CFG_COUNT_UP_BIT = 8;
  localparam int unsigned CFG_WD_EN_BIT    = 5;
  localparam int unsigned CFG_LSB          = 1;
  localparam int unsigned CFG_MSB          = 8;

  // Status field positions
  localparam int unsigned STS_IRQ_BIT     = 0;
  localparam int unsigned STS_WD_BIT      = 1;
  localparam int unsigned STS_TRIPPED_BIT = 2;

  // Prescale codes and the last prescaler count for each divisor
  localparam logic [1:0] PRE_DIV16    = 2'b01;
  localparam logic [1:0] PRE_DIV256   = 2'b10;
  localparam logic [7:0] PRE_LAST_1   = 8'h00;
  localparam logic [7:0] PRE_LAST_16  = 8'h0f;
  localparam logic [7:0] PRE_LAST_256 = 8'hff;

  // Counter and shift register constants
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_FULL  = 16'hffff;
  localparam logic [15:0] COUNT_ONE   = 16'h0001;
  localparam logic [15:0] LOAD_RESET  = 16'h0000;
  localparam logic [7:0]  LFSR_MASK   = 8'h63;
  localparam logic [7:0]  LFSR_RESET  = 8'h00;

  // Configuration bits 8..1, in register order
  typedef struct packed {
    logic       count_up;
    logic       enable;
    logic       periodic;
    logic       wd_en;
    logic       secure;
    logic [1:0] prescale;
    logic       irq_opt;
  } wdt_cfg_t;

  localparam wdt_cfg_t CFG_RESET = 8'h00;

  typedef enum logic [2:0] {
    MODE_NORMAL   = 3'b001,
    MODE_WATCHDOG = 3'b010,
    MODE_TRIPPED  = 3'b100
  } wdt_mode_t;

endpackage

// File: verilog/wdt_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Normal mode: 32 kHz, /1 /16 /256, down only
// - Config bit 5 enters watchdog; clear at reset
// - Watchdog counts down from load value
// - Full load at /256 gives 512 s
// - Watchdog always runs from 32 kHz tick
// - Expiry: reset, or interrupt when bit 1 set
// - Accepted service reloads counter, new period
// - Watchdog mode locks load and config until reset
// - Load and count are 16 bits; count read-only
// - Clear register 8 bits; clears normal interrupt
// - Bit 4 secure: service must equal LFSR value
// - LFSR 8 bits, X8+X6+X5+X+1
// - Clear write before watchdog captures the seed
// - Matching service steps LFSR at reload
// - Mismatched service resets immediately
// - Zero seed always causes immediate reset; here only in secure mode, at the first service
// - LFSR state never readable
// - First service equals seed, then successive states
// - Bits 8,7,6: count-up, enable, periodic; reset clear
// - Prescale 00=/1, 01=/16, 10=/256, 11=/1
// - Normal mode interrupt on reaching zero; clear removes
module wdt_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             wdt_irq,
  output logic             cpu_reset_req
);

  // Bus slave state
  logic               wait_q;
  logic [31:0]        rdata_q;
  logic [31:0]        rd_mux;

  // Output flip-flops
  logic               irq_q;
  logic               cpu_reset_q;

  // Software-visible registers
  wdt_pkg::wdt_cfg_t  cfg_q;
  wdt_pkg::wdt_cfg_t  cfg_d;
  wdt_pkg::wdt_mode_t mode_q;
  logic [15:0]        load_q;
  logic [15:0]        load_d;
  logic [15:0]        count_q;

  // Service sequence
  logic [7:0]         lfsr_q;
  logic [7:0]         lfsr_next;

  // Timebase
  logic [10:0]        div_q;
  logic [7:0]         pre_q;
  logic [7:0]         pre_last;
  logic               slow_tick;
  logic               running;
  logic               step;

  // Bus decode
  logic               wr_go;
  logic               wr_load;
  logic               wr_config;
  logic               wr_clear;
  logic               unlocked;

  // Watchdog service decode
  logic               enter_wd;
  logic               svc_write;
  logic               svc_ok;
  logic               svc_bad;
  logic               reload_svc;

  // Counter events
  logic               wd_expire;
  logic               norm_zero;
  logic               irq_set;
  logic               irq_clr;
  logic               trip;

  // A request is served in the cycle where waitrequest is already low
  // Decoding from the live address is safe: the master holds it
  // until it has sampled waitrequest low, so the strobe and the
  // address always agree at the completion edge
  // Clear writes need lane 0, where the written value lives
  assign wr_go     = avs_write && !wait_q;
  assign wr_load   = wr_go && (avs_address == wdt_pkg::OFS_LOAD);
  assign wr_config = wr_go && (avs_address == wdt_pkg::OFS_CONFIG);
  assign wr_clear  = wr_go && (avs_address == wdt_pkg::OFS_CLEAR) && avs_byteenable[0];
  assign unlocked  = (mode_q == wdt_pkg::MODE_NORMAL);

  // Byte-lane merges for the two writable registers
  // Lane 0 carries load bits 7:0 and config bits 7:1
  // Lane 1 carries load bits 15:8 and the count-up bit
  // Lanes 2 and 3 have nothing behind them
  // Bit 0 of the config word is reserved and never stored
  always_comb
  begin
    load_d = load_q;
    cfg_d  = cfg_q;
    if (avs_byteenable[0])
    begin
      load_d[7:0] = avs_writedata[7:0];
      cfg_d[6:0]  = avs_writedata[7:1];
    end
    if (avs_byteenable[1])
    begin
      load_d[15:8] = avs_writedata[15:8];
      cfg_d[7]     = avs_writedata[wdt_pkg::CFG_COUNT_UP_BIT];
    end
  end

  // Read multiplexer; the shift register has no read path at all
  // Keeping the LFSR off this mux is deliberate: software must
  // track the sequence itself, so a leaked state would defeat
  // the secure clear
  // The clear register reads as zero through the default arm
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      wdt_pkg::OFS_LOAD:   rd_mux[15:0] = load_q;
      wdt_pkg::OFS_COUNT:  rd_mux[15:0] = count_q;
      wdt_pkg::OFS_CONFIG: rd_mux[wdt_pkg::CFG_MSB:wdt_pkg::CFG_LSB] = cfg_q;
      // Status bits are a snapshot of flag and mode
      wdt_pkg::OFS_STATUS:
      begin
        rd_mux[wdt_pkg::STS_IRQ_BIT]     = irq_q;
        rd_mux[wdt_pkg::STS_WD_BIT]      = (mode_q == wdt_pkg::MODE_WATCHDOG);
        rd_mux[wdt_pkg::STS_TRIPPED_BIT] = (mode_q == wdt_pkg::MODE_TRIPPED);
      end
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus slave: one wait cycle, then a single cycle with waitrequest low
  // Read data are captured in the wait cycle and then held, so
  // they stand at the completion edge and until the next request, which zeroes them if it is a write
  // The cost is a fixed two-cycle access, which the register
  // traffic here can easily afford
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    // Completion edge: back to waiting
    else if (!wait_q)
    begin
      wait_q <= 1'b1;
    end
    // Request seen: answer in the next cycle
    else if (avs_read || avs_write)
    begin
      wait_q  <= 1'b0;
      rdata_q <= avs_read ? rd_mux : 32'h0000_0000;
    end
  end

  // Slow tick divider; rounding keeps the tick within 0.03 % of 32 kHz
  // The divider free-runs from reset and is never restarted, so
  // the first step after an enable can come early by up to one
  // tick; a watchdog period is accurate to one step, as a service reload does not restart pre_q
  // Every timer decision below is taken on this single pulse
  assign slow_tick = (div_q == wdt_pkg::SLOW_DIV_LAST);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      div_q <= 11'h000;
    else if (slow_tick)
      div_q <= 11'h000;
    else
      div_q <= div_q + 11'h001;
  end

  // Prescaler last count; code 11 falls back to divide by one
  // A last count rather than a divisor keeps the compare small
  // and lets divide by one fall out as a last count of zero
  // The same compare serves normal and watchdog mode
  always_comb
  begin
    case (cfg_q.prescale)
      wdt_pkg::PRE_DIV16:  pre_last = wdt_pkg::PRE_LAST_16;
      wdt_pkg::PRE_DIV256: pre_last = wdt_pkg::PRE_LAST_256;
      default:             pre_last = wdt_pkg::PRE_LAST_1;
    endcase
  end

  // Watchdog runs regardless of the enable bit
  // Ignoring the enable in watchdog mode means software cannot
  // stop the watchdog by clearing bit 7, and since the config
  // register is locked it could not do so anyway
  // A step is one prescaled tick of the 32 kHz timebase
  assign running = (unlocked && cfg_q.enable)
                   || (mode_q == wdt_pkg::MODE_WATCHDOG);
  assign step    = running && slow_tick && (pre_q >= pre_last);

  // Prescaler held at zero while stopped so a start is clean
  // A prescale change while running takes effect at once; the
  // partial count is kept, so the first period may be short
  // Software that needs exact periods changes it while stopped
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      pre_q <= 8'h00;
    else if (!running)
      pre_q <= 8'h00;
    else if (slow_tick)
      pre_q <= (pre_q >= pre_last) ? 8'h00 : pre_q + 8'h01;
  end

  // Entering watchdog mode and servicing it
  // Entry needs lane 0, where the watchdog enable bit lives
  // A service is any clear write made while the watchdog runs;
  // in secure mode it must also match a non-zero LFSR state
  // A zero state can never match, which makes a zero seed
  // always fatal as soon as the first service arrives
  assign enter_wd   = wr_config && unlocked && avs_byteenable[0]
                      && avs_writedata[wdt_pkg::CFG_WD_EN_BIT];
  assign svc_write  = wr_clear && (mode_q == wdt_pkg::MODE_WATCHDOG);
  assign svc_ok     = !cfg_q.secure
                      || ((avs_writedata[7:0] == lfsr_q)
                      && (lfsr_q != 8'h00));
  assign svc_bad    = svc_write && !svc_ok;
  assign reload_svc = svc_write && svc_ok;
  // Expiry is reported every step while stuck at zero; harmless repeats
  // With the interrupt option the flag is simply set again
  assign wd_expire  = step
                      && (mode_q == wdt_pkg::MODE_WATCHDOG)
                      && (count_q <= wdt_pkg::COUNT_ONE);
  assign norm_zero  = step && unlocked && (count_q == wdt_pkg::COUNT_ONE);
  // A service in the expiry cycle counts as in time
  // It was written within the period, so it is honoured
  assign trip       = svc_bad
                      || (wd_expire && !reload_svc && !cfg_q.irq_opt);

  // Down counter; count-up bit is stored but has no effect
  // Priority: entry and service reloads first, then a load
  // write in normal mode, then the step itself
  // In watchdog mode the count stops at zero instead of
  // wrapping, so a missed expiry is reported again next step
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      count_q <= wdt_pkg::COUNT_RESET;
    else if (enter_wd || reload_svc)
      count_q <= load_q;
    else if (wr_load && unlocked)
      count_q <= load_d;
    else if (step)
    begin
      if (mode_q == wdt_pkg::MODE_WATCHDOG)
      begin
        if (count_q != wdt_pkg::COUNT_RESET)
          count_q <= count_q - wdt_pkg::COUNT_ONE;
      end
      else if (count_q == wdt_pkg::COUNT_RESET)
        count_q <= cfg_q.periodic ? load_q : wdt_pkg::COUNT_FULL;
      else
        count_q <= count_q - wdt_pkg::COUNT_ONE;
    end
  end

  // Load and configuration registers, locked once watchdog is on
  // The lock follows the mode, and only rst_n returns the mode
  // to normal, so no software write can lift it
  // Locked writes are still answered on the bus, just dropped
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      load_q <= wdt_pkg::LOAD_RESET;
      cfg_q  <= wdt_pkg::CFG_RESET;
    end
    else
    begin
      if (wr_load && unlocked)
        load_q <= load_d;
      if (wr_config && unlocked)
        cfg_q <= cfg_d;
    end
  end

  // Galois form of the polynomial, shifting left
  // Taps at x6, x5, x1 and x0 form the feedback mask; the
  // Galois form needs one XOR level per bit, which suits a
  // single-cycle step at the reload edge
  // The seed is any clear write in normal mode, the last one wins
  assign lfsr_next = {lfsr_q[6:0], 1'b0}
                     ^ (lfsr_q[7] ? wdt_pkg::LFSR_MASK : 8'h00);

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      lfsr_q <= wdt_pkg::LFSR_RESET;
    else if (wr_clear && unlocked)
      lfsr_q <= avs_writedata[7:0];
    else if (reload_svc && cfg_q.secure)
      lfsr_q <= lfsr_next;
  end

  // Mode sequencing; trip takes watchdog to tripped, only rst_n returns either to normal
  // Tripped is kept as its own state so that nothing else
  // happens after a reset request: no steps, no services, no
  // further interrupts while the system reacts
  // An illegal code falls back to normal, the reset state
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      mode_q <= wdt_pkg::MODE_NORMAL;
    else
    begin
      case (mode_q)
        wdt_pkg::MODE_NORMAL:
          if (enter_wd)
            mode_q <= wdt_pkg::MODE_WATCHDOG;
        wdt_pkg::MODE_WATCHDOG:
          if (trip)
            mode_q <= wdt_pkg::MODE_TRIPPED;
        wdt_pkg::MODE_TRIPPED:
          mode_q <= wdt_pkg::MODE_TRIPPED;
        default:
          mode_q <= wdt_pkg::MODE_NORMAL;
      endcase
    end
  end

  // Reset request holds until the system pulls rst_n
  // A pulse could be missed by a slow reset controller, so
  // the request is a level that only the reset itself drops
  // A mismatched secure clear write or an expiry without the interrupt option sets it; no clear write drops it
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      cpu_reset_q <= 1'b0;
    else if (trip)
      cpu_reset_q <= 1'b1;
  end

  // Interrupt flag; a set in the clearing cycle wins
  // Losing a set would hide an expiry from software, while a
  // spurious extra interrupt only costs one more clear write
  // An accepted service also drops a pending watchdog interrupt
  assign irq_set = norm_zero
                   || (wd_expire && cfg_q.irq_opt && !reload_svc);
  assign irq_clr = (wr_clear && unlocked) || reload_svc;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      irq_q <= 1'b0;
    else if (irq_set)
      irq_q <= 1'b1;
    else if (irq_clr)
      irq_q <= 1'b0;
  end

  // Outputs come straight from their flip-flops
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign wdt_irq         = irq_q;
  assign cpu_reset_req   = cpu_reset_q;

endmodule
